/* src/dgir_pkg.sv */
// constants and types shared by the dual group interrupt router
// assumes a single chip clock domain and active high asynchronous reset
`default_nettype none

package dgir_pkg;

  localparam int unsigned NUM_LINES     = 8;
  localparam int unsigned SEL_W         = 3;
  localparam int unsigned NUM_EXT       = 2;
  localparam int unsigned NUM_INT_SRC   = 18;
  localparam int unsigned SRC_A_DEFAULT = 9;
  localparam int unsigned SRC_B_DEFAULT = 9;
  localparam int unsigned DUP_LINES     = 2;

  // which external input feeds which group
  localparam int unsigned EXT_GROUP_A   = 0;
  localparam int unsigned EXT_GROUP_B   = 1;

  // polarity encodings for output lines and external inputs
  localparam logic        POL_ACT_HIGH  = 1'b0;
  localparam logic        POL_ACT_LOW   = 1'b1;

  // values after reset
  localparam logic [7:0]  LINE_OE_N_RST = 8'hff;
  localparam logic [7:0]  LINE_VAL_RST  = 8'h00;
  localparam logic        SEC_OE_N_RST  = 1'b1;
  localparam logic        SEC_VAL_RST   = 1'b0;
  localparam logic        PIN_LVL_RST   = 1'b0;

  typedef logic [SEL_W-1:0]     dgir_sel_t;
  typedef logic [NUM_LINES-1:0] dgir_lines_t;

endpackage : dgir_pkg

`default_nettype wire

/* src/dgir_pin_filter.sv */
// three-stage synchroniser for asynchronous input pins
// a new level is taken once the second and third stages agree
`default_nettype none

module dgir_pin_filter #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);
  import dgir_pkg::*;

  if (WIDTH == 0) begin : g_width_check
    $error("pin filter needs at least one input");
  end

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= {WIDTH{PIN_LVL_RST}};
      s2_r <= {WIDTH{PIN_LVL_RST}};
      s3_r <= {WIDTH{PIN_LVL_RST}};
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit: follow only when the two later stages agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_o <= {WIDTH{PIN_LVL_RST}};
    end else if (ce_i) begin
      level_o <= (s2_r & s3_r) | (level_o & (s2_r | s3_r));
    end
  end

endmodule : dgir_pin_filter

`default_nettype wire

/* src/dgir_router.sv */
// dual group interrupt router: gathers internal and external interrupt
// conditions into two groups and routes them onto eight open-drain lines
// assumes sources are synchronous to clk_i; external inputs are raw pins
//
// How it works
// RULE_01 - separate lines assert together per group
// RULE_02 - shared line asserts while either group pends
// RULE_03 - duplication drives lines 0 and 1 too
// RULE_04 - polarity 0 asserts high, 1 asserts low
// RULE_05 - three-bit select picks one of eight lines
// RULE_06 - group enable gates its routed line
// RULE_07 - two external inputs with polarity and enable
// RULE_08 - each group has its own secondary output
// RULE_09 - eighteen internal sources are accepted
// RULE_10 - software sets polarity and select before enable
// RULE_11 - software avoids reselecting a line mid-operation
// RULE_12 - group A: input timing, ext 0, counter 0
// RULE_13 - external polarity 0 high, 1 low
// RULE_14 - pending is OR; idle lines are released
`default_nettype none

module dgir_router
  import dgir_pkg::*;
#(
  parameter int unsigned NUM_SRC_A = dgir_pkg::SRC_A_DEFAULT,
  parameter int unsigned NUM_SRC_B = dgir_pkg::SRC_B_DEFAULT
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           ce_i,
  // analog input timing and counter 0 conditions
  input  wire logic [NUM_SRC_A-1:0]           src_a_i,
  input  wire logic [NUM_SRC_A-1:0]           src_a_en_i,
  input  wire logic [NUM_SRC_A-1:0]           src_a_sec_en_i,
  // analog output timing and counter 1 conditions
  input  wire logic [NUM_SRC_B-1:0]           src_b_i,
  input  wire logic [NUM_SRC_B-1:0]           src_b_en_i,
  input  wire logic [NUM_SRC_B-1:0]           src_b_sec_en_i,
  // external interrupt pins and their settings
  input  wire logic [dgir_pkg::NUM_EXT-1:0]   ext_irq_i,
  input  wire logic [dgir_pkg::NUM_EXT-1:0]   ext_pol_i,
  input  wire logic [dgir_pkg::NUM_EXT-1:0]   ext_en_i,
  input  wire logic [dgir_pkg::NUM_EXT-1:0]   ext_sec_en_i,
  // group configuration
  input  wire logic                           group_a_en_i,
  input  wire dgir_pkg::dgir_sel_t            group_a_sel_i,
  input  wire logic                           group_b_en_i,
  input  wire dgir_pkg::dgir_sel_t            group_b_sel_i,
  input  wire logic                           group_a_sec_en_i,
  input  wire logic                           group_b_sec_en_i,
  input  wire logic                           out_pol_i,
  input  wire logic                           dup_3pin_i,
  // open-drain interrupt lines, enables low while driving
  output logic      [dgir_pkg::NUM_LINES-1:0] irq_line_o,
  output logic      [dgir_pkg::NUM_LINES-1:0] irq_line_oe_n_o,
  output logic                                secondary_output_group_a_o,
  output logic                                secondary_output_group_a_oe_n_o,
  output logic                                secondary_output_group_b_o,
  output logic                                secondary_output_group_b_oe_n_o,
  // group pending status
  output logic                                pend_a_o,
  output logic                                pend_b_o
);
  import dgir_pkg::*;

  if (NUM_SRC_A + NUM_SRC_B != NUM_INT_SRC) begin : g_src_check
    $error("source counts of the two groups must add up to the internal total");
  end
  if (NUM_SRC_A == 0 || NUM_SRC_B == 0) begin : g_src_nonzero
    $error("each group needs at least one internal source");
  end

  logic [NUM_EXT-1:0] ext_lvl;
  logic [NUM_EXT-1:0] ext_act;
  logic               pend_a;
  logic               pend_b;
  logic               req_a;
  logic               req_b;
  logic               sec_a;
  logic               sec_b;
  dgir_lines_t        line_req;

  dgir_pin_filter #(
    .WIDTH   (NUM_EXT)
  ) u_ext_filter (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .pin_i   (ext_irq_i),
    .level_o (ext_lvl)
  );

  // external input active level after per-input polarity
  assign ext_act = ext_lvl ^ ext_pol_i; // [RULE_13] [RULE_07]

  // group pending is the OR of enabled conditions
  assign pend_a = (|(src_a_i & src_a_en_i))                        // [RULE_09] [RULE_14]
                | (ext_act[EXT_GROUP_A] & ext_en_i[EXT_GROUP_A]);  // [RULE_12] [RULE_07]
  assign pend_b = (|(src_b_i & src_b_en_i))                        // [RULE_09] [RULE_14]
                | (ext_act[EXT_GROUP_B] & ext_en_i[EXT_GROUP_B]);  // [RULE_12] [RULE_07]

  assign req_a = group_a_en_i & pend_a; // [RULE_06]
  assign req_b = group_b_en_i & pend_b; // [RULE_06]

  // secondary outputs take their own source selection and enable
  assign sec_a = group_a_sec_en_i
               & ((|(src_a_i & src_a_sec_en_i))
                  | (ext_act[EXT_GROUP_A] & ext_sec_en_i[EXT_GROUP_A])); // [RULE_08]
  assign sec_b = group_b_sec_en_i
               & ((|(src_b_i & src_b_sec_en_i))
                  | (ext_act[EXT_GROUP_B] & ext_sec_en_i[EXT_GROUP_B])); // [RULE_08]

  // per line request: routed groups, plus duplication onto lines 0 and 1
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      line_req[i] = (req_a && group_a_sel_i == SEL_W'(i))   // [RULE_05] [RULE_01]
                  | (req_b && group_b_sel_i == SEL_W'(i));  // [RULE_02]
      if (i < DUP_LINES) begin
        line_req[i] = line_req[i] | (dup_3pin_i & (req_a | req_b)); // [RULE_03]
      end
    end
  end

  // lines are driven only while requested, released otherwise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_line_oe_n_o <= LINE_OE_N_RST;
    end else if (ce_i) begin
      irq_line_oe_n_o <= ~line_req; // [RULE_14] [RULE_01] [RULE_02]
    end
  end

  // driven level follows the output polarity
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_line_o <= LINE_VAL_RST;
    end else if (ce_i) begin
      irq_line_o <= {NUM_LINES{out_pol_i == POL_ACT_HIGH}}; // [RULE_04]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      secondary_output_group_a_o      <= SEC_VAL_RST;
      secondary_output_group_a_oe_n_o <= SEC_OE_N_RST;
      secondary_output_group_b_o      <= SEC_VAL_RST;
      secondary_output_group_b_oe_n_o <= SEC_OE_N_RST;
    end else if (ce_i) begin
      secondary_output_group_a_o      <= (out_pol_i == POL_ACT_HIGH); // [RULE_04]
      secondary_output_group_a_oe_n_o <= ~sec_a;                      // [RULE_08]
      secondary_output_group_b_o      <= (out_pol_i == POL_ACT_HIGH); // [RULE_04]
      secondary_output_group_b_oe_n_o <= ~sec_b;                      // [RULE_08]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_a_o <= 1'b0;
      pend_b_o <= 1'b0;
    end else if (ce_i) begin
      pend_a_o <= pend_a; // [RULE_14]
      pend_b_o <= pend_b; // [RULE_14]
    end
  end

  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_group_a_route: assert property ( // [RULE_05]
    ce_i && req_a |=> !irq_line_oe_n_o[$past(group_a_sel_i)])
    else $error("group A request did not drive its selected line");

  a_group_b_route: assert property ( // [RULE_05]
    ce_i && req_b |=> !irq_line_oe_n_o[$past(group_b_sel_i)])
    else $error("group B request did not drive its selected line");

  a_groups_off_idle: assert property ( // [RULE_06]
    ce_i && !group_a_en_i && !group_b_en_i |=> (irq_line_oe_n_o == LINE_OE_N_RST))
    else $error("a line was driven with both groups disabled");

  a_two_lines_both: assert property ( // [RULE_01]
    ce_i && req_a && req_b && group_a_sel_i != group_b_sel_i
    |=> $countones(~irq_line_oe_n_o) >= 2)
    else $error("two routed groups did not drive two lines");

  a_shared_one_line: assert property ( // [RULE_02]
    ce_i && !dup_3pin_i && group_a_sel_i == group_b_sel_i && (req_a || req_b)
    |=> $countones(~irq_line_oe_n_o) == 1)
    else $error("shared line case drove other than one line");

  a_dup_line_pair: assert property ( // [RULE_03]
    ce_i && dup_3pin_i && (req_a || req_b)
    |=> !irq_line_oe_n_o[0] && !irq_line_oe_n_o[1])
    else $error("duplication did not drive lines 0 and 1");

  a_line_polarity: assert property ( // [RULE_04]
    ce_i ##1 !irq_line_oe_n_o[0] |-> irq_line_o[0] == ($past(out_pol_i) == POL_ACT_HIGH))
    else $error("driven line level does not match output polarity");

  a_ext_pin_path: assert property ( // [RULE_13]
    ce_i && ext_irq_i[0] ##1 ce_i && ext_irq_i[0] ##1 ce_i [*2]
    ##1 ce_i && ext_pol_i[0] == POL_ACT_HIGH && ext_en_i[0] && group_a_en_i
    |=> !irq_line_oe_n_o[$past(group_a_sel_i)])
    else $error("external input 0 did not reach group A line");

  a_secondary_a: assert property ( // [RULE_08]
    ce_i |=> secondary_output_group_a_oe_n_o == !$past(sec_a))
    else $error("secondary output A does not follow its request");

  a_idle_release: assert property ( // [RULE_14]
    ce_i && !req_a && !req_b |=> (irq_line_oe_n_o == LINE_OE_N_RST))
    else $error("a line stayed driven with no pending group");

  a_freeze_hold: assert property (
    !ce_i |=> $stable(irq_line_oe_n_o) && $stable(secondary_output_group_b_oe_n_o))
    else $error("state changed while clock enable was low");

endmodule : dgir_router

`default_nettype wire

/* bench/dgir_host_model.sv */
// host bus side of the eight open-drain interrupt lines
// assumes each line has a pull-up and is pulled only while its enable is low
`default_nettype none

module dgir_host_model (
  input  wire logic [7:0] line_i,
  input  wire logic [7:0] oe_n_i,
  output logic      [7:0] wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released line floats up to the pull-up level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wire_o[i] = oe_n_i[i] ? 1'b1 : line_i[i];
    end
  end
endmodule : dgir_host_model

`default_nettype wire

/* bench/dgir_router_test.sv */
// self-checking bench for the dual group interrupt router
// assumes router, pin filter and host model compiled before this file
`default_nettype none

module dgir_router_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dgir_pkg::*;
  typedef struct packed {
    dgir_lines_t oe_n;
    dgir_lines_t val;
    dgir_lines_t lvl;
    logic [5:0]  flg;
  } dgir_exp_s;
  logic        clk, rst, ce, ga_en, gb_en, ga_sec, gb_sec, pol, dup;
  logic [8:0]  sa, sa_en, sa_sec, sb, sb_en, sb_sec;
  logic [1:0]  ext, ext_pol, ext_en, ext_sec;
  dgir_sel_t   ga_sel, gb_sel;
  dgir_lines_t line, oe_n, lvl;
  logic        sav, saoe, sbv, sboe, pa, pb;
  logic [1:0]  hist [3];
  logic [1:0]  flt;
  dgir_exp_s   q [$];
  dgir_exp_s   last;
  int          num_errors, total_checks, seed;

  dgir_router u_dgir_router (
    .clk_i(clk), .rst_i(rst), .ce_i(ce),
    .src_a_i(sa), .src_a_en_i(sa_en), .src_a_sec_en_i(sa_sec),
    .src_b_i(sb), .src_b_en_i(sb_en), .src_b_sec_en_i(sb_sec),
    .ext_irq_i(ext), .ext_pol_i(ext_pol), .ext_en_i(ext_en), .ext_sec_en_i(ext_sec),
    .group_a_en_i(ga_en), .group_a_sel_i(ga_sel), .group_b_en_i(gb_en),
    .group_b_sel_i(gb_sel), .group_a_sec_en_i(ga_sec), .group_b_sec_en_i(gb_sec),
    .out_pol_i(pol), .dup_3pin_i(dup), .irq_line_o(line), .irq_line_oe_n_o(oe_n),
    .secondary_output_group_a_o(sav), .secondary_output_group_a_oe_n_o(saoe),
    .secondary_output_group_b_o(sbv), .secondary_output_group_b_oe_n_o(sboe),
    .pend_a_o(pa), .pend_b_o(pb)
  );
  dgir_host_model u_dgir_host_model (.line_i(line), .oe_n_i(oe_n), .wire_o(lvl));

  task automatic cmp8(input dgir_lines_t got, input dgir_lines_t exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp6(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp6

  // expected outputs for the coming edge; pins pass three stages and the agreement filter
  function automatic dgir_exp_s calc();
    dgir_exp_s  e;
    logic [1:0] act;
    logic       ra, rb, qa, qb;
    act = flt ^ ext_pol;
    e.flg[1] = |(sa & sa_en) | (act[0] & ext_en[0]);
    e.flg[0] = |(sb & sb_en) | (act[1] & ext_en[1]);
    qa = ga_sec & (|(sa & sa_sec) | (act[0] & ext_sec[0]));
    qb = gb_sec & (|(sb & sb_sec) | (act[1] & ext_sec[1]));
    ra = ga_en & e.flg[1];
    rb = gb_en & e.flg[0];
    for (int i = 0; i < 8; i++) begin
      e.oe_n[i] = !((ra && ga_sel == i) || (rb && gb_sel == i) || (dup && i < 2 && (ra || rb)));
    end
    e.val = {8{~pol}};
    e.lvl = e.val | e.oe_n;
    e.flg[5:2] = {~pol, ~qa, ~pol, ~qb};
    return e;
  endfunction : calc

  // mode 0 free routing, 1 both groups on one line, 2 external pins only
  task automatic drive(input int mode, input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      ce = ($random(seed) & 7) != 0;
      if (k % 8 == 0) begin
        {ga_en, gb_en} = 2'h0; // settle polarity and line before enabling
        {ga_sel, gb_sel, pol, dup, ext_pol, ext} = 12'($random(seed));
        if (mode == 1) gb_sel = ga_sel;
      end else begin
        {ga_en, gb_en} = 2'($random(seed));
      end
      {ga_sec, gb_sec, ext_en, ext_sec} = 6'($random(seed));
      {sa, sb} = 18'($random(seed) & $random(seed));
      if (mode == 2) {sa, sb} = '0;
      {sa_en, sb_en} = 18'($random(seed));
      {sa_sec, sb_sec} = 18'($random(seed));
      if (ce) begin
        last = calc();
        flt = (hist[1] & hist[2]) | (flt & (hist[1] | hist[2]));
        hist[2] = hist[1];
        hist[1] = hist[0];
        hist[0] = ext;
      end
      q.push_back(last);
    end
  endtask : drive

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    dgir_exp_s e;
    forever begin
      @(posedge clk);
      #1;
      if (q.size() > 0) begin
        e = q.pop_front();
        cmp8(oe_n, e.oe_n);
        cmp8(line, e.val);
        cmp8(lvl, e.lvl);
        cmp6({sav, saoe, sbv, sboe, pa, pb}, e.flg);
      end
    end
  end

  initial begin
    seed = 32'h10af_6710;
    rst = 1'b1;
    {sa, sa_en, sa_sec, sb, sb_en, sb_sec, ext, ext_pol, ext_en, ext_sec} = '0;
    {ce, ga_en, gb_en, ga_sec, gb_sec, pol, dup, ga_sel, gb_sel} = '0;
    hist = '{default: 2'h0};
    flt = 2'h0;
    last = {8'hff, 8'h00, 8'hff, 6'h14};
    @(negedge clk);
    cmp8(oe_n, 8'hff);
    cmp6({sav, saoe, sbv, sboe, pa, pb}, 6'h14);
    @(negedge clk);
    rst = 1'b0;
    for (int m = 0; m < 3; m++) begin
      drive(m, 800);
      $display("test %0d done mismatches=%0d", m, num_errors);
    end
    for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge clk);
    #2;
    if (q.size() > 0) num_errors++;
    end_sim();
  end
endmodule : dgir_router_test

`default_nettype wire
